//--- src/srx_defines.vh
`ifndef SRX_DEFINES_VH
`define SRX_DEFINES_VH

// Register map
`define SRX_A_FIFO_EMPTY   12'h30d
`define SRX_A_SYNC_MASK    12'h311
`define SRX_A_SYNC_DUR     12'h312
`define SRX_A_MF_PERIOD    12'h313
`define SRX_A_TEST_EN      12'h315
`define SRX_A_TEST_CTRL    12'h316
`define SRX_A_THR_LO       12'h317
`define SRX_A_THR_MID      12'h318
`define SRX_A_THR_HI       12'h319
`define SRX_A_CNT_LO       12'h31a
`define SRX_A_CNT_MID      12'h31b
`define SRX_A_CNT_HI       12'h31c
`define SRX_A_PASS         12'h31d

// Field positions
`define SRX_MASK_FRAME     0
`define SRX_MASK_RSVD      1
`define SRX_MASK_MF        2
`define SRX_ERR_DUR        7:4
`define SRX_REQ_DUR        3:0
`define SRX_CTRL_LANE      6:4
`define SRX_CTRL_PAT       3:2
`define SRX_CTRL_RUN       1
`define SRX_CTRL_CLR       0

// Reset values
`define SRX_RST_BYTE       8'h00
`define SRX_RST_PASS       8'hff

// Pattern codes
`define SRX_PAT_P7         2'h0
`define SRX_PAT_P15        2'h1
`define SRX_PAT_P31        2'h2

// Link framing
`define SRX_LANES          8
`define SRX_WORD           32
`define SRX_OCT_PER_CYC    4
`define SRX_REQ_FRAMES     5
`define SRX_REQ_OCTETS     9
`define SRX_CNT_W          24

`endif

//--- src/srx_sync_prbs.v
`timescale 1ns/100ps
`include "srx_defines.vh"

module srx_sync_prbs #(
	parameter FRAME_OCTETS = 4
) (
	input  wire                               i_mclk,
	input  wire                               i_reset_n,
	input  wire [11:0]                        i_reg_addr,
	input  wire                               i_reg_wr,
	input  wire                               i_reg_rd,
	input  wire [7:0]                         i_reg_wdata,
	output reg  [7:0]                         o_reg_rdata,
	input  wire [`SRX_LANES-1:0]              i_fifo_empty,
	input  wire                               i_frame_loss,
	input  wire                               i_multiframe_loss,
	input  wire                               i_sync_needed,
	input  wire                               i_sync_error,
	input  wire                               i_multiframe_tick,
	input  wire [`SRX_LANES*`SRX_WORD-1:0]    i_lane_data,
	output wire                               o_sync_request_out_n
);

	// Request low time at field zero, rounded up to whole cycles
	localparam [7:0] REQ_BASE = (`SRX_REQ_FRAMES * FRAME_OCTETS + `SRX_REQ_OCTETS
		+ `SRX_OCT_PER_CYC - 1) / `SRX_OCT_PER_CYC;

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_REQ  = 2'h1;
	localparam [1:0] ST_ERR  = 2'h2;

	reg  [7:0]                  mask_r;
	reg  [7:0]                  dur_r;
	reg  [7:0]                  mf_period_r;
	reg  [7:0]                  mf_cnt_r;
	reg  [7:0]                  test_en_r;
	reg  [6:0]                  ctrl_r;
	reg  [`SRX_CNT_W-1:0]       thr_r;
	reg  [1:0]                  state_r;
	reg  [7:0]                  low_cnt_r;
	reg                         sync_n_r;
	wire                        req_trig;
	wire                        test_run;
	wire                        test_clr;
	wire [`SRX_CNT_W*`SRX_LANES-1:0] cnt_all;
	wire [`SRX_LANES-1:0]       fail_all;
	wire [`SRX_CNT_W-1:0]       cnt_sel;

	// Self-synchronising checker: each bit is predicted from the two tap
	// bits before it, so no seed exchange with the transmitter is needed.
	// Bit 0 of a word is the earliest in time.
	function [5:0] f_errs(input [63:0] hist, input [1:0] sel);
		integer n;
		integer t1;
		integer t2;
		reg     [5:0] acc;
		begin
			acc = 6'h00;
			t1 = 6;
			t2 = 7;
			if (sel == `SRX_PAT_P15) begin
				t1 = 14;
				t2 = 15;
			end else if (sel == `SRX_PAT_P31) begin
				t1 = 28;
				t2 = 31;
			end
			for (n = 32; n < 64; n = n + 1) begin
				if (hist[n] ^ hist[n-t1] ^ hist[n-t2])
					acc = acc + 6'h01;
			end
			f_errs = acc;
		end
	endfunction

	// Register writes over the configuration port
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mask_r    <= `SRX_RST_BYTE;
			dur_r     <= `SRX_RST_BYTE;
			test_en_r <= `SRX_RST_BYTE;
			ctrl_r    <= 7'h00;
			thr_r     <= 24'h000000;
		end else if (i_reg_wr) begin
			if (i_reg_addr == `SRX_A_SYNC_MASK)
				mask_r <= {5'h00, i_reg_wdata[2:0]};
			else if (i_reg_addr == `SRX_A_SYNC_DUR)
				dur_r <= i_reg_wdata;
			else if (i_reg_addr == `SRX_A_TEST_EN)
				test_en_r <= i_reg_wdata;
			else if (i_reg_addr == `SRX_A_TEST_CTRL)
				ctrl_r <= i_reg_wdata[6:0];
			else if (i_reg_addr == `SRX_A_THR_LO)
				thr_r[7:0] <= i_reg_wdata;
			else if (i_reg_addr == `SRX_A_THR_MID)
				thr_r[15:8] <= i_reg_wdata;
			else if (i_reg_addr == `SRX_A_THR_HI)
				thr_r[23:16] <= i_reg_wdata;
		end
	end

	// Lane select into the count readback
	assign cnt_sel = cnt_all[ctrl_r[`SRX_CTRL_LANE]*`SRX_CNT_W +: `SRX_CNT_W];

	// Registered read data, one cycle after the read strobe
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_reg_rdata <= `SRX_RST_BYTE;
		end else if (i_reg_rd) begin
			if (i_reg_addr == `SRX_A_FIFO_EMPTY)
				o_reg_rdata <= i_fifo_empty;
			else if (i_reg_addr == `SRX_A_SYNC_MASK)
				o_reg_rdata <= mask_r;
			else if (i_reg_addr == `SRX_A_SYNC_DUR)
				o_reg_rdata <= dur_r;
			else if (i_reg_addr == `SRX_A_MF_PERIOD)
				o_reg_rdata <= mf_period_r;
			else if (i_reg_addr == `SRX_A_TEST_EN)
				o_reg_rdata <= test_en_r;
			else if (i_reg_addr == `SRX_A_TEST_CTRL)
				o_reg_rdata <= {1'b0, ctrl_r};
			else if (i_reg_addr == `SRX_A_THR_LO)
				o_reg_rdata <= thr_r[7:0];
			else if (i_reg_addr == `SRX_A_THR_MID)
				o_reg_rdata <= thr_r[15:8];
			else if (i_reg_addr == `SRX_A_THR_HI)
				o_reg_rdata <= thr_r[23:16];
			else if (i_reg_addr == `SRX_A_CNT_LO)
				o_reg_rdata <= cnt_sel[7:0];
			else if (i_reg_addr == `SRX_A_CNT_MID)
				o_reg_rdata <= cnt_sel[15:8];
			else if (i_reg_addr == `SRX_A_CNT_HI)
				o_reg_rdata <= cnt_sel[23:16];
			else if (i_reg_addr == `SRX_A_PASS)
				o_reg_rdata <= ~fail_all;
			else
				o_reg_rdata <= `SRX_RST_BYTE;
		end
	end

	// Multiframe period: cycles between ticks; the count stops at 255, so any period over 255 reads as 0
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mf_cnt_r    <= 8'h00;
			mf_period_r <= `SRX_RST_BYTE;
		end else if (i_multiframe_tick) begin
			mf_period_r <= mf_cnt_r + 8'h01;
			mf_cnt_r    <= 8'h00;
		end else if (mf_cnt_r != 8'hff) begin
			mf_cnt_r <= mf_cnt_r + 8'h01;
		end
	end

	// Anything that asks the transmitter to resynchronise
	assign req_trig = i_sync_needed
		| (i_multiframe_loss & mask_r[`SRX_MASK_MF])
		| (i_frame_loss & mask_r[`SRX_MASK_FRAME]);

	// Sync request generator; a request outranks and cuts short an error
	// report, and a fresh trigger reloads the low time.
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r   <= ST_IDLE;
			low_cnt_r <= 8'h00;
			sync_n_r  <= 1'b1;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (req_trig) begin
						state_r   <= ST_REQ;
						low_cnt_r <= REQ_BASE + {4'h0, dur_r[`SRX_REQ_DUR]} - 8'h01;
						sync_n_r  <= 1'b0;
					end else if (i_sync_error) begin
						state_r   <= ST_ERR;
						low_cnt_r <= {4'h0, dur_r[`SRX_ERR_DUR]};
						sync_n_r  <= 1'b0;
					end
				end
				ST_REQ, ST_ERR: begin
					if (req_trig) begin
						state_r   <= ST_REQ;
						low_cnt_r <= REQ_BASE + {4'h0, dur_r[`SRX_REQ_DUR]} - 8'h01;
					end else if (low_cnt_r == 8'h00) begin
						state_r  <= ST_IDLE;
						sync_n_r <= 1'b1;
					end else begin
						low_cnt_r <= low_cnt_r - 8'h01;
					end
				end
				default: begin
					state_r  <= ST_IDLE;
					sync_n_r <= 1'b1;
				end
			endcase
		end
	end

	assign o_sync_request_out_n = sync_n_r;

	// Test gating; clear dominates run so software can zero mid-test
	assign test_clr = ctrl_r[`SRX_CTRL_CLR];
	assign test_run = (test_en_r != 8'h00) & ctrl_r[`SRX_CTRL_RUN] & ~test_clr;

	// One checker per lane
	genvar g;
	generate
		for (g = 0; g < `SRX_LANES; g = g + 1) begin : g_lane
			reg  [`SRX_WORD-1:0]   prev_r;
			reg                    primed_r;
			reg  [`SRX_CNT_W-1:0]  cnt_r;
			reg                    fail_r;
			wire [`SRX_WORD-1:0]   word;
			wire [5:0]             errs;
			wire [`SRX_CNT_W:0]    sum;

			assign word = i_lane_data[g*`SRX_WORD +: `SRX_WORD];
			assign errs = f_errs({word, prev_r}, ctrl_r[`SRX_CTRL_PAT]);
			assign sum  = {1'b0, cnt_r} + {19'h00000, errs};

			// First word after start only fills history; counts saturate
			always @(posedge i_mclk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					prev_r   <= 32'h00000000;
					primed_r <= 1'b0;
					cnt_r    <= 24'h000000;
					fail_r   <= 1'b0;
				end else if (test_clr) begin
					primed_r <= 1'b0;
					cnt_r    <= 24'h000000;
					fail_r   <= 1'b0;
				end else if (test_run) begin
					prev_r   <= word;
					primed_r <= 1'b1;
					if (primed_r) begin
						cnt_r <= sum[`SRX_CNT_W] ? {`SRX_CNT_W{1'b1}} : sum[`SRX_CNT_W-1:0];
						if (sum[`SRX_CNT_W] || (sum[`SRX_CNT_W-1:0] >= thr_r
							&& sum[`SRX_CNT_W-1:0] != 24'h000000))
							fail_r <= 1'b1;
					end
				end else begin
					primed_r <= 1'b0;
				end
			end

			assign cnt_all[g*`SRX_CNT_W +: `SRX_CNT_W] = cnt_r;
			assign fail_all[g] = fail_r;
		end
	endgenerate

endmodule

//--- tb/serial_rx_sync_gen_and_prbs_test.sv
`timescale 1ns/100ps
module serial_rx_sync_gen_and_prbs_test_test;
	reg          i_mclk = 1'b0;
	reg          i_reset_n = 1'b0;
	reg  [11:0]  addr = 12'h000;
	reg          wr_s = 1'b0;
	reg          rd_s = 1'b0;
	reg  [7:0]   wdata = 8'h00;
	reg  [7:0]   fifo_e = 8'h00;
	reg  [3:0]   ev = 4'h0;
	reg          tick = 1'b0;
	reg  [7:0]   flip = 8'h00;
	reg  [31:0]  seed = 32'h7f71;
	reg          rd_due = 1'b0;
	wire [255:0] lanes;
	wire [7:0]   rdata;
	wire         sync_n;
	logic [7:0]  exp_q[$];
	integer      n_mismatch = 0;
	integer      num_checks = 0;
	integer      i;

	srx_sync_prbs u_srx_sync_prbs (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_reg_addr(addr),
		.i_reg_wr(wr_s), .i_reg_rd(rd_s), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.i_fifo_empty(fifo_e), .i_frame_loss(ev[0]), .i_multiframe_loss(ev[1]),
		.i_sync_needed(ev[2]), .i_sync_error(ev[3]), .i_multiframe_tick(tick),
		.i_lane_data(lanes), .o_sync_request_out_n(sync_n));
	srx_tx_model u_srx_tx_model (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_flip(flip),
		.o_lane_data(lanes));

	always #50 i_mclk = ~i_mclk;

	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input string what, input [7:0] seen, input [7:0] want);
		num_checks = num_checks + 1;
		if (seen !== want) begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task step(input integer n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task wr(input [11:0] a, input [7:0] d);
		addr = a;
		wdata = d;
		wr_s = 1'b1;
		step(1);
		wr_s = 1'b0;
		step(1);
	endtask
	// Expected read value is queued; the watcher below compares it
	task rd(input [11:0] a, input [7:0] e);
		exp_q.push_back(e);
		addr = a;
		rd_s = 1'b1;
		step(1);
		rd_s = 1'b0;
		step(1);
	endtask
	// One-cycle event, then count low cycles of the sync output
	task pulse(input [3:0] e, input [7:0] w);
		integer n;
		n = 0;
		ev = e;
		step(1);
		ev = 4'h0;
		for (i = 0; i < 30; i = i + 1) begin
			@(negedge i_mclk);
			n = n + !sync_n;
		end
		step(1);
		chk("sync_low", n[7:0], w);
	endtask
	task inject;
		flip = 8'h08;
		step(1);
		flip = 8'h00;
		step(3);
	endtask

	// Read data lands one cycle after its strobe; sampled mid-cycle
	always @(posedge i_mclk) rd_due <= rd_s;
	always @(negedge i_mclk) if (rd_due) chk("rdata", rdata, exp_q.pop_front());

	initial begin
		step(16);
		i_reset_n = 1'b1;
		rd(12'h311, 8'h00);
		rd(12'h312, 8'h00);
		rd(12'h313, 8'h00);
		rd(12'h315, 8'h00);
		rd(12'h316, 8'h00);
		rd(12'h31d, 8'hff);
		for (int r = 0; r < 4; r++) begin
			seed = lfsr(seed);
			fifo_e = seed[7:0];
			rd(12'h30d, seed[7:0]);
		end
		wr(12'h311, 8'hfa);
		rd(12'h311, 8'h02);
		pulse(4'h2, 8'h00);
		pulse(4'h1, 8'h00);
		wr(12'h311, 8'h05);
		pulse(4'h2, 8'h08);
		pulse(4'h1, 8'h08);
		pulse(4'h4, 8'h08);
		pulse(4'h8, 8'h01);
		wr(12'h312, 8'hff);
		pulse(4'h4, 8'h17);
		pulse(4'h8, 8'h10);
		// Boundary ticks twenty cycles apart
		repeat (2) begin
			tick = 1'b1;
			step(1);
			tick = 1'b0;
			step(19);
		end
		rd(12'h313, 8'h14);
		wr(12'h317, 8'h02);
		rd(12'h317, 8'h02);
		wr(12'h315, 8'h01);
		wr(12'h316, 8'h32);
		step(4);
		inject;
		rd(12'h31a, 8'h03);
		rd(12'h31b, 8'h00);
		rd(12'h31c, 8'h00);
		rd(12'h31d, 8'hf7);
		wr(12'h316, 8'h72);
		rd(12'h31a, 8'h00);
		wr(12'h316, 8'h30);
		inject;
		rd(12'h31a, 8'h03);
		wr(12'h316, 8'h31);
		rd(12'h31a, 8'h00);
		rd(12'h31d, 8'hff);
		wr(12'h315, 8'h00);
		wr(12'h316, 8'h3e);
		step(3);
		inject;
		rd(12'h31a, 8'h00);
		wr(12'h315, 8'h01);
		step(3);
		inject;
		rd(12'h31a, 8'h03);
		close_out;
	end
endmodule

//--- tb/srx_sync_prbs_assertions.sv
`timescale 1ns/100ps
// Sync request timing and read port checks
module srx_sync_prbs_assertions (
	input wire        i_mclk,
	input wire        i_reset_n,
	input wire [11:0] i_reg_addr,
	input wire        i_reg_wr,
	input wire        i_reg_rd,
	input wire [7:0]  i_reg_wdata,
	input wire [7:0]  o_reg_rdata,
	input wire [7:0]  i_fifo_empty,
	input wire        i_frame_loss,
	input wire        i_multiframe_loss,
	input wire        i_sync_needed,
	input wire        i_sync_error,
	input wire        o_sync_request_out_n
);
	reg  [2:0] mask_r;
	reg  [7:0] dur_r;
	wire       trig;
	wire       s_n;
	// Any cause that must start a request
	assign trig = i_sync_needed | (i_multiframe_loss & mask_r[2]) | (i_frame_loss & mask_r[0]);
	assign s_n  = o_sync_request_out_n;
	// Shadow copies, since mask and durations are not visible at the ports
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mask_r <= 3'h0;
			dur_r  <= 8'h00;
		end else if (i_reg_wr) begin
			if (i_reg_addr == 12'h311) mask_r <= i_reg_wdata[2:0];
			if (i_reg_addr == 12'h312) dur_r <= i_reg_wdata;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	mf_loss_low_a: assert property (i_multiframe_loss && mask_r[2] |=> !s_n)
		else $error("multiframe loss left sync high");
	frame_loss_low_a: assert property (i_frame_loss && mask_r[0] |=> !s_n)
		else $error("frame loss left sync high");
	resync_low_a: assert property (i_sync_needed |=> !s_n)
		else $error("resync left sync high");
	idle_high_a: assert property (s_n && !trig && !i_sync_error |=> s_n)
		else $error("sync fell without cause");
	req_width_a: assert property (
		s_n && i_sync_needed && dur_r[3:0] == 4'h0 |=> (!s_n)[*8] ##1 s_n)
		else $error("request low time wrong");
	err_width_a: assert property (
		s_n && i_sync_error && !trig && dur_r[7:4] == 4'h0 |=> !s_n ##1 s_n)
		else $error("error low time wrong");
	fifo_read_a: assert property (
		i_reg_rd && i_reg_addr == 12'h30d |=> o_reg_rdata == $past(i_fifo_empty))
		else $error("fifo empty byte wrong");
	rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data moved without read");
endmodule

bind srx_sync_prbs srx_sync_prbs_assertions u_srx_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
	.i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_fifo_empty(i_fifo_empty),
	.i_frame_loss(i_frame_loss), .i_multiframe_loss(i_multiframe_loss),
	.i_sync_needed(i_sync_needed), .i_sync_error(i_sync_error),
	.o_sync_request_out_n(o_sync_request_out_n));

//--- tb/srx_tx_model.sv
`timescale 1ns/100ps
// PRBS7 source on all eight lanes, bit 0 sent first
module srx_tx_model (
	input  wire         i_mclk,
	input  wire         i_reset_n,
	input  wire [7:0]   i_flip,
	output reg  [255:0] o_lane_data
);
	reg [6:0]  h;
	reg [31:0] w;
	integer    k;
	// One flipped bit costs three checker errors, as each bit feeds two later taps
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			h = 7'h7f;
			o_lane_data <= 256'h0;
		end else begin
			for (k = 0; k < 32; k = k + 1) begin
				w[k] = h[5] ^ h[6];
				h = {h[5:0], w[k]};
			end
			// Non-blocking so the checker samples last cycle's word, not a race
			for (k = 0; k < 8; k = k + 1) o_lane_data[k*32+:32] <= w ^ {26'h0, i_flip[k], 5'h0};
		end
	end
endmodule
